// *** hw/ascd_pkg.sv ***
package ascd_pkg;
   // Timing of the sampled device clock and of this controller
   localparam int CLK_PERIOD_NS = 5;
   localparam int DEVICE_CLOCK_PERIOD_NS = 489;
   localparam int DECODE_CLKS = 4;
   localparam int RESET_CLKS = 18;
   localparam int GAP_CYC =
      (DECODE_CLKS * DEVICE_CLOCK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_CYC =
      (RESET_CLKS * DEVICE_CLOCK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_W = 12;
   localparam int SCLK_HALF_CYC = 5;
   localparam int DIV_W = 4;
   localparam int BYTE_W = 8;
   localparam int IDX_W = 6;
   localparam int FRAME_BYTES = 27;
   localparam int FIFO_DEPTH = 8;
   // Single-byte opcodes
   localparam logic [7:0] OPC_WAKEUP = 8'h02;
   localparam logic [7:0] OPC_STANDBY = 8'h04;
   localparam logic [7:0] OPC_RESET = 8'h06;
   localparam logic [7:0] OPC_START = 8'h08;
   localparam logic [7:0] OPC_STOP = 8'h0a;
   localparam logic [7:0] OPC_CONT_READ = 8'h10;
   localparam logic [7:0] OPC_STOP_CONT = 8'h11;
   localparam logic [7:0] OPC_SINGLE_READ = 8'h12;
   localparam logic [7:0] OPC_FILL = 8'h00;
   // Prefixes of the register access bytes
   localparam logic [2:0] PFX_REG_READ = 3'h1;
   localparam logic [2:0] PFX_REG_WRITE = 3'h2;
   localparam logic [2:0] PFX_COUNT = 3'h0;
   // Reset values of the tracked device modes and pins
   localparam logic CONT_RESET = 1'b1;
   localparam logic START_PIN_LEVEL = 1'b0;
   typedef enum logic [3:0] {
      OP_WAKEUP, OP_STANDBY, OP_RESET, OP_START, OP_STOP, OP_CONT_READ,
      OP_STOP_CONT, OP_SINGLE_READ, OP_REG_READ, OP_REG_WRITE, OP_FRAME_READ
   } ascd_op_e;
   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT_READY, ST_LOAD, ST_SHIFT, ST_GAP
   } ascd_state_e;
endpackage

// *** hw/ascd_host.sv ***
`timescale 1ns/1ps
module ascd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_q;
   logic [AW-1:0] rdPtr_q;
   logic [AW:0] count_q;
   logic push;
   logic pop;

   assign inReady = count_q != (AW+1)'(DEPTH);
   assign outValid = count_q != '0;
   assign outData = mem[rdPtr_q];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
         end
         if (pop) begin
            rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
         end
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module ascd_host
   import ascd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic cmdValid,
   output logic cmdReady,
   input wire ascd_op_e cmdOp,
   input wire logic [4:0] cmdAddr,
   input wire logic [4:0] cmdCount,
   output logic cmdReject,
   output logic busy,
   output logic inStandby,
   output logic contRead,
   input wire logic wrValid,
   output logic wrReady,
   input wire logic [BYTE_W-1:0] wrData,
   output logic rdValid,
   input wire logic rdReady,
   output logic [BYTE_W-1:0] rdData,
   output logic sclk,
   output logic mosi,
   input wire logic miso,
   output logic csN,
   output logic startPin,
   input wire logic dataReadyN
);
   ascd_state_e st_q;
   ascd_op_e op_q;
   logic [4:0] addr_q;
   logic [4:0] count_q;
   logic [IDX_W-1:0] idx_q;
   logic [IDX_W-1:0] lastIdx_q;
   logic [BYTE_W-1:0] shift_q;
   logic [2:0] bit_q;
   logic [DIV_W-1:0] div_q;
   logic [TIMER_W-1:0] timer_q;
   logic [TIMER_W-1:0] since_q;
   logic sclk_q, mosi_q, csN_q, final_q, standby_q, cont_q, reject_q;
   logic misoMeta_q, miso_q, readyMetaN_q, readyN_q, readyDlyN_q, resultPend_q;
   logic fifoInValid_q;
   logic [BYTE_W-1:0] fifoInData_q;
   logic fifoInReady, readyFell, keepOut, accept, legal, needWr, isRx, loadOk;
   logic halfDone, byteDone;

   function automatic logic [IDX_W-1:0] lastIndex(ascd_op_e op, logic [4:0] cnt);
      case (op)
         OP_SINGLE_READ: lastIndex = IDX_W'(FRAME_BYTES);
         OP_FRAME_READ: lastIndex = IDX_W'(FRAME_BYTES - 1);
         OP_REG_READ, OP_REG_WRITE: lastIndex = IDX_W'(cnt) + IDX_W'(2);
         default: lastIndex = '0;
      endcase
   endfunction

   function automatic logic [7:0] txByte(ascd_op_e op, logic [IDX_W-1:0] idx,
                                         logic [4:0] adr, logic [4:0] cnt,
                                         logic [7:0] wd);
      txByte = OPC_FILL;
      case (op)
         OP_WAKEUP: txByte = OPC_WAKEUP;
         OP_STANDBY: txByte = OPC_STANDBY;
         OP_RESET: txByte = OPC_RESET;
         OP_START: txByte = OPC_START;
         OP_STOP: txByte = OPC_STOP;
         OP_CONT_READ: txByte = OPC_CONT_READ;
         OP_STOP_CONT: txByte = OPC_STOP_CONT;
         OP_SINGLE_READ: txByte = (idx == '0) ? OPC_SINGLE_READ : OPC_FILL;
         OP_REG_READ, OP_REG_WRITE: begin
            if (idx == '0) begin
               txByte = {(op == OP_REG_READ) ? PFX_REG_READ : PFX_REG_WRITE, adr};
            end else if (idx == IDX_W'(1)) begin
               txByte = {PFX_COUNT, cnt};
            end else if (op == OP_REG_WRITE) begin
               txByte = wd;
            end
         end
         default: txByte = OPC_FILL;
      endcase
   endfunction

   // Pins from the device pass two flops before use
   always_ff @(posedge sys_clk) begin
      misoMeta_q <= miso;
      miso_q <= misoMeta_q;
      readyMetaN_q <= dataReadyN;
      readyN_q <= readyMetaN_q;
      readyDlyN_q <= readyN_q;
   end

   assign readyFell = readyDlyN_q && !readyN_q;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         since_q <= TIMER_W'(GAP_CYC);
      end else if (readyFell) begin
         since_q <= '0;
      end else if (since_q != TIMER_W'(GAP_CYC)) begin
         since_q <= since_q + 1'b1;
      end
   end

   // Fresh result pending; a new fall wins over the clear
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         resultPend_q <= 1'b0;
      end else if (readyFell) begin
         resultPend_q <= 1'b1;
      end else if (st_q == ST_WAIT_READY) begin
         resultPend_q <= 1'b0;
      end
   end

   assign keepOut = since_q != TIMER_W'(GAP_CYC) || !readyN_q;

   always_comb begin
      if (standby_q) begin
         legal = cmdOp == OP_WAKEUP;
      end else if (cont_q) begin
         legal = cmdOp == OP_STOP_CONT || cmdOp == OP_FRAME_READ;
      end else begin
         legal = cmdOp != OP_FRAME_READ && cmdOp != OP_WAKEUP;
      end
   end

   assign cmdReady = st_q == ST_IDLE && !(cmdOp == OP_CONT_READ && keepOut && legal);
   assign accept = cmdValid && cmdReady;
   assign needWr = op_q == OP_REG_WRITE && idx_q >= IDX_W'(2);
   assign isRx = op_q == OP_FRAME_READ || (op_q == OP_SINGLE_READ && idx_q != '0) ||
                 (op_q == OP_REG_READ && idx_q >= IDX_W'(2));
   assign loadOk = (!needWr || wrValid) && (!isRx || fifoInReady);
   assign wrReady = st_q == ST_LOAD && needWr && loadOk;
   assign halfDone = div_q == DIV_W'(SCLK_HALF_CYC - 1);
   assign byteDone = st_q == ST_SHIFT && halfDone && sclk_q && bit_q == 3'h7;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_q <= ST_IDLE;
         op_q <= OP_WAKEUP;
         addr_q <= '0;
         count_q <= '0;
         idx_q <= '0;
         lastIdx_q <= '0;
         timer_q <= '0;
         final_q <= 1'b0;
         reject_q <= 1'b0;
      end else begin
         reject_q <= accept && !legal;
         case (st_q)
            ST_IDLE: begin
               if (accept && legal) begin
                  op_q <= cmdOp;
                  addr_q <= cmdAddr;
                  count_q <= cmdCount;
                  idx_q <= '0;
                  final_q <= 1'b0;
                  lastIdx_q <= lastIndex(cmdOp, cmdCount);
                  if (cmdOp == OP_SINGLE_READ || cmdOp == OP_FRAME_READ) begin
                     st_q <= ST_WAIT_READY;
                  end else begin
                     st_q <= ST_LOAD;
                  end
               end
            end
            ST_WAIT_READY: begin
               if (resultPend_q && !readyN_q) begin
                  st_q <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               if (loadOk) begin
                  st_q <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (byteDone) begin
                  st_q <= ST_GAP;
                  if (idx_q == lastIdx_q) begin
                     final_q <= 1'b1;
                     if (op_q == OP_RESET) begin
                        timer_q <= TIMER_W'(RESET_CYC);
                     end else if (op_q == OP_SINGLE_READ || op_q == OP_FRAME_READ) begin
                        timer_q <= '0;
                     end else begin
                        timer_q <= TIMER_W'(GAP_CYC);
                     end
                  end else begin
                     idx_q <= idx_q + 1'b1;
                     if ((op_q == OP_REG_READ && idx_q < IDX_W'(2)) || op_q == OP_REG_WRITE) begin
                        timer_q <= TIMER_W'(GAP_CYC);
                     end else begin
                        timer_q <= '0;
                     end
                  end
               end
            end
            ST_GAP: begin
               if (timer_q != '0) begin
                  timer_q <= timer_q - 1'b1;
               end else if (final_q) begin
                  st_q <= ST_IDLE;
               end else begin
                  st_q <= ST_LOAD;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // Serial clock made here by division; device samples on the falling edge
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         div_q <= '0;
         bit_q <= '0;
         sclk_q <= 1'b0;
         mosi_q <= 1'b0;
         shift_q <= '0;
      end else if (st_q == ST_LOAD) begin
         div_q <= '0;
         bit_q <= '0;
         shift_q <= txByte(op_q, idx_q, addr_q, count_q, wrData);
      end else if (st_q == ST_SHIFT) begin
         div_q <= halfDone ? '0 : div_q + 1'b1;
         if (halfDone) begin
            sclk_q <= !sclk_q;
            if (!sclk_q) begin
               mosi_q <= shift_q[7];
            end else begin
               shift_q <= {shift_q[6:0], miso_q};
               bit_q <= bit_q + 1'b1;
            end
         end
      end else begin
         sclk_q <= 1'b0;
      end
   end

   // Chip select held low across every byte and gap of one command
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         csN_q <= 1'b1;
      end else if (st_q == ST_LOAD && loadOk) begin
         csN_q <= 1'b0;
      end else if (st_q == ST_IDLE) begin
         csN_q <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         fifoInValid_q <= 1'b0;
         fifoInData_q <= '0;
      end else begin
         fifoInValid_q <= byteDone && isRx;
         if (byteDone) begin
            fifoInData_q <= {shift_q[6:0], miso_q};
         end
      end
   end

   // Device modes as seen from here, updated once a command has gone out
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cont_q <= CONT_RESET;
         standby_q <= 1'b0;
      end else if (byteDone && idx_q == lastIdx_q) begin
         case (op_q)
            OP_STANDBY: standby_q <= 1'b1;
            OP_WAKEUP: standby_q <= 1'b0;
            OP_RESET: cont_q <= CONT_RESET;
            OP_CONT_READ: cont_q <= 1'b1;
            OP_STOP_CONT: cont_q <= 1'b0;
            default: cont_q <= cont_q;
         endcase
      end
   end

   ascd_fifo #(
      .WIDTH(BYTE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_rxFifo (
      .sys_clk(sys_clk),
      .reset(reset),
      .inValid(fifoInValid_q),
      .inReady(fifoInReady),
      .inData(fifoInData_q),
      .outValid(rdValid),
      .outReady(rdReady),
      .outData(rdData)
   );

   assign cmdReject = reject_q;
   assign busy = st_q != ST_IDLE;
   assign inStandby = standby_q;
   assign contRead = cont_q;
   assign sclk = sclk_q;
   assign mosi = mosi_q;
   assign csN = csN_q;
   assign startPin = START_PIN_LEVEL;
endmodule

// *** test/ascd_host_props.sv ***
`timescale 1ns/1ps
module ascd_host_props
   import ascd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic cmdValid,
   input wire logic cmdReady,
   input wire ascd_op_e cmdOp,
   input wire logic cmdReject,
   input wire logic busy,
   input wire logic inStandby,
   input wire logic contRead,
   input wire logic sclk,
   input wire logic csN,
   input wire logic startPin
);
   logic acc;
   ascd_op_e opQ;
   logic [15:0] busyCnt;
   assign acc = cmdValid && cmdReady;
   always_ff @(posedge sys_clk) begin
      if (acc) begin
         opQ <= cmdOp;
      end
   end
   // Length of the current busy stretch, for the post-command gaps
   always_ff @(posedge sys_clk) begin
      busyCnt <= (reset || !busy) ? 16'h0000 : busyCnt + 16'h0001;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_standby_only_wake: assert property (acc && inStandby && cmdOp != OP_WAKEUP |=> cmdReject)
      else $error("command other than leave-standby taken in standby");
   a_cont_drops_read: assert property (acc && contRead && cmdOp == OP_REG_READ |=> cmdReject)
      else $error("register read taken in continuous mode");
   a_cont_needs_stop: assert property (acc && contRead && cmdOp == OP_START |=> cmdReject)
      else $error("start taken in continuous mode");
   a_stop_cont_clears: assert property (acc && !inStandby && cmdOp == OP_STOP_CONT
      |-> ##[1:600] !contRead) else $error("continuous mode not cancelled");
   a_reset_cont_on: assert property ($fell(reset) |-> contRead)
      else $error("continuous mode off after reset");
   a_sys_cmd_gap: assert property ($fell(busy) && opQ inside {OP_WAKEUP, OP_START, OP_STOP}
      |-> busyCnt >= GAP_CYC + 70) else $error("gap after command too short");
   a_reset_gap: assert property ($fell(busy) && opQ == OP_RESET |-> busyCnt >= RESET_CYC + 70)
      else $error("gap after reset command too short");
   a_cs_framed: assert property ($fell(csN) |-> busy)
      else $error("chip select low outside a command");
   a_sclk_idle: assert property (csN |-> !sclk)
      else $error("serial clock moves while deselected");
   a_start_low: assert property (!startPin)
      else $error("start pin driven high");
endmodule

// *** test/ascd_dev_model.sv ***
`timescale 1ns/1ps
module ascd_dev_model
   import ascd_pkg::*;
#(
   parameter int DR_PERIOD_NS = 30000
) (
   input wire logic sclk,
   input wire logic mosi,
   output logic miso,
   input wire logic csN,
   input wire logic startPin,
   output logic dataReadyN
);
   logic [7:0] regs[32];
   logic [7:0] rxSr, txSr;
   logic [7:0] txq[$];
   logic lastBit = 1'b0;
   int rxCnt = 0, txCnt = 0, st = 0, addr, left;
   bit wr, running = 0, cont = 1, standby = 0;
   initial dataReadyN = 1'b1;
   initial regs = '{default: 8'h00};
   // Released line shows the inverse of its last bit
   assign miso = csN ? ~lastBit : lastBit;
   task automatic load_frame();
      txq.delete();
      txCnt = 0;
      for (int i = 0; i < FRAME_BYTES; i++) txq.push_back(8'h5a + 8'(i));
   endtask
   task automatic decode(logic [7:0] b);
      if (st == 1) begin
         left = int'(b[4:0]) + 1;
         st = wr ? 2 : 0;
         txq.delete();
         // Drop any half-shifted stale frame byte
         txCnt = 0;
         if (!wr) for (int i = 0; i < left; i++) txq.push_back(regs[(addr + i) % 32]);
      end else if (st == 2) begin
         regs[addr % 32] = b;
         addr++;
         left--;
         if (left == 0) st = 0;
      end else if (standby && b != OPC_WAKEUP) begin
      end else if ((b[7:5] == PFX_REG_READ && !cont) || b[7:5] == PFX_REG_WRITE) begin
         wr = b[6];
         addr = b[4:0];
         st = 1;
      end else begin
         case (b)
            OPC_WAKEUP: standby = 0;
            OPC_STANDBY: standby = 1;
            OPC_START: running = 1;
            OPC_STOP: running = 0;
            OPC_RESET: begin
               regs = '{default: 8'h00};
               cont = 1;
            end
            OPC_CONT_READ: cont = 1;
            OPC_STOP_CONT: cont = 0;
            OPC_SINGLE_READ: load_frame();
            default: ;
         endcase
      end
   endtask
   always @(negedge sclk) if (!csN) begin
      rxSr = {rxSr[6:0], mosi};
      rxCnt++;
      if (rxCnt == 8) begin
         rxCnt = 0;
         decode(rxSr);
      end
   end
   always @(posedge sclk) if (!csN) begin
      if (txCnt == 0 && txq.size() > 0) begin
         txSr = txq.pop_front();
         txCnt = 8;
      end
      if (txCnt > 0) begin
         lastBit = txSr[7];
         txSr = txSr << 1;
         txCnt--;
      end else if (cont) begin
         lastBit = dataReadyN;
      end else lastBit = ~lastBit;
   end
   always begin
      #(DR_PERIOD_NS);
      if (running || startPin) begin
         dataReadyN = 1'b0;
         if (cont) load_frame();
         #4000 dataReadyN = 1'b1;
      end
   end
endmodule

// *** test/tb_adc_spi_command_decoder.sv ***
`timescale 1ns/1ps
module tb_adc_spi_command_decoder;
   import ascd_pkg::*;
   logic sys_clk = 1'b0, reset = 1'b1, cmdValid = 1'b0, wrValid = 1'b0, rdReady = 1'b0;
   ascd_op_e cmdOp = OP_WAKEUP;
   logic [4:0] cmdAddr = 5'h00, cmdCount = 5'h00;
   logic [7:0] wrData = 8'h00, rdData;
   logic cmdReady, cmdReject, busy, inStandby, contRead, wrReady, rdValid, sclk, mosi, miso;
   logic csN, startPin, dataReadyN;
   int num_errors = 0, n_compared = 0, regs[32], expQ[$];
   logic [7:0] wq[$];
   ascd_host i_dut (.*);
   ascd_dev_model i_dev (.*);
   always #2.5 sys_clk = ~sys_clk;
   task automatic check_bit(string what, logic exp, logic got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic check_byte(string what, logic [7:0] exp, logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Read bytes leave the buffer under a randomly stalling consumer
   always @(posedge sys_clk) begin
      if (!reset && rdValid && rdReady) begin
         if (expQ.size() == 0) check_bit("extra read byte", 1'b0, 1'b1);
         else check_byte("read byte", 8'(expQ.pop_front()), rdData);
      end
      #1 rdReady = $urandom_range(0, 3) != 0;
   end
   always @(posedge sys_clk) begin
      if (wrValid && wrReady) void'(wq.pop_front());
      #1 wrValid = wq.size() > 0;
      wrData = (wq.size() > 0) ? wq[0] : 8'h00;
   end
   task automatic do_cmd(ascd_op_e op, int a, int n, logic rej);
      int k;
      cmdOp = op;
      cmdAddr = 5'(a);
      cmdCount = 5'(n);
      cmdValid = 1'b1;
      k = 0;
      do begin
         @(negedge sys_clk);
         k++;
      end while (!cmdReady && k < 20000);
      @(posedge sys_clk);
      #1 cmdValid = 1'b0;
      check_bit("reject", rej, cmdReject);
      check_bit("busy", !rej, busy);
      k = 0;
      while (busy === 1'b1 && k < 30000) begin
         @(posedge sys_clk);
         #1 k++;
      end
      @(posedge sys_clk);
      #1 check_bit("busy ended", 1'b0, busy);
   endtask
   task automatic drain();
      int k = 0;
      while (expQ.size() > 0 && k < 3000) begin
         @(posedge sys_clk);
         k++;
      end
      @(posedge sys_clk);
      #1 check_bit("all bytes read", 1'b1, expQ.size() == 0);
   endtask
   task automatic push_frame();
      for (int i = 0; i < FRAME_BYTES; i++) expQ.push_back((8'h5a + i) % 256);
   endtask
   task automatic reg_access(int a, int n);
      for (int i = 0; i <= n; i++) begin
         regs[(a + i) % 32] = $urandom_range(0, 255);
         wq.push_back(8'(regs[(a + i) % 32]));
      end
      do_cmd(OP_REG_WRITE, a, n, 1'b0);
      for (int i = 0; i <= n; i++) expQ.push_back(regs[(a + i) % 32]);
      do_cmd(OP_REG_READ, a, n, 1'b0);
      drain();
   endtask
   initial begin
      #500000;
      num_errors++;
      $display("mismatch watchdog expected finish seen timeout");
      stop_test();
   end
   initial begin
      void'($urandom(89));
      repeat (8) @(posedge sys_clk);
      #1 reset = 1'b0;
      check_bit("contRead after reset", 1'b1, contRead);
      check_bit("startPin", 1'b0, startPin);
      $display("test defaults done");
      do_cmd(OP_REG_READ, 0, 0, 1'b1);
      do_cmd(OP_START, 0, 0, 1'b1);
      do_cmd(OP_STOP_CONT, 0, 0, 1'b0);
      check_bit("contRead cleared", 1'b0, contRead);
      do_cmd(OP_FRAME_READ, 0, 0, 1'b1);
      $display("test continuous interlock done");
      do_cmd(OP_STANDBY, 0, 0, 1'b0);
      check_bit("standby", 1'b1, inStandby);
      do_cmd(OP_STOP, 0, 0, 1'b1);
      do_cmd(OP_WAKEUP, 0, 0, 1'b0);
      check_bit("awake", 1'b0, inStandby);
      $display("test standby done");
      for (int t = 0; t < 3; t++) reg_access($urandom_range(0, 31), $urandom_range(8, 15));
      reg_access(31, 0);
      $display("test registers done");
      do_cmd(OP_START, 0, 0, 1'b0);
      do_cmd(OP_START, 0, 0, 1'b0);
      push_frame();
      do_cmd(OP_SINGLE_READ, 0, 0, 1'b0);
      drain();
      $display("test single read done");
      do_cmd(OP_RESET, 0, 0, 1'b0);
      check_bit("contRead after reset command", 1'b1, contRead);
      regs = '{default: 0};
      do_cmd(OP_STOP_CONT, 0, 0, 1'b0);
      for (int i = 0; i < 32; i++) expQ.push_back(0);
      do_cmd(OP_REG_READ, 0, 31, 1'b0);
      drain();
      $display("test reset command done");
      do_cmd(OP_CONT_READ, 0, 0, 1'b0);
      push_frame();
      do_cmd(OP_FRAME_READ, 0, 0, 1'b0);
      drain();
      do_cmd(OP_STOP_CONT, 0, 0, 1'b0);
      do_cmd(OP_STOP, 0, 0, 1'b0);
      $display("test continuous read done");
      stop_test();
   end
endmodule
bind ascd_host ascd_host_props i_props (.*);
